// ### hw/sbsi_core.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// - All synchronous pins are sampled only on the rising clock edge.
// - Output enable and sleep request act without waiting for a clock edge.
// - Either active-low address strobe starts a burst and loads the address.
// - A 2-bit counter on the low address bits advances when advance is low.
// - A new external address may be loaded every cycle without penalty.
// - Deselect passes the same two pipeline stages as a read.
// - With byte gate low, each low lane select writes its lane.
// - All-byte write low writes all four lanes, ignoring gate and selects.
// - Read when all-byte high and gate high or selects all high.
// - Data pins stay undriven in the output cycle of every write.
// - Sleep request high or stopped clock gives standby, contents kept.
// - Sleep request defaults low, so a loose pin means active operation.
// - Order select low is linear, high interleaved; floating means interleaved.
// - Linear order counts up modulo four from the start value.
// - Interleaved order is start value XOR a 0,1,2,3 count.
// - The two low address inputs are also the counter preset.
// - Selected only when second enable high, first and third low.
// - Writes complete internally; data is only needed at the sampling edge.
// - Output enable high kills drivers; low enables only during read data.
// - Dummy reads with output enable high still advance the counter.
module sbsi_core #(
   parameter int ADDR_W = sbsi_pkg::SBSI_ADDR_W,
   parameter int LANE_W = sbsi_pkg::SBSI_LANE_W
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] address,
   input wire sbsi_pkg::sbsi_enable_t enables,
   input wire sbsi_pkg::sbsi_strobe_t strobes,
   input wire sbsi_pkg::sbsi_write_t writeCtl,
   input wire logic [sbsi_pkg::SBSI_LANES*LANE_W-1:0] dataIn,
   input wire logic outputEnableN,
   input wire logic sleepRequest,
   input wire logic burstOrderSelect,
   output logic [sbsi_pkg::SBSI_LANES*LANE_W-1:0] dataOut,
   output logic [sbsi_pkg::SBSI_LANES-1:0] dataDriveN,
   output logic standby
);
   import sbsi_pkg::*;

   localparam int DATA_W = SBSI_LANES * LANE_W;
   localparam int DEPTH = 1 << ADDR_W;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // The burst field needs the two low bits plus at least one more
   if (ADDR_W < SBSI_BURST_W + 1 || ADDR_W > 24) begin : g_badAddr
      $error("sbsi_core: ADDR_W must lie in 3..24");
   end
   if (LANE_W < 1) begin : g_badLane
      $error("sbsi_core: LANE_W must be at least 1");
   end

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];
   sbsi_state_t state_q;
   sbsi_state_t state_d;
   logic [ADDR_W-1:0] base_q;
   logic [ADDR_W-1:0] base_d;
   logic [1:0] count_q;
   logic [1:0] count_d;
   logic readPend_q;
   logic readPend_d;
   logic [DATA_W-1:0] readData_q;
   logic [DATA_W-1:0] readData_d;
   logic driveEn_q;
   logic driveEn_d;
   logic [DATA_W-1:0] dataOut_q;
   logic [DATA_W-1:0] dataOut_d;
   logic standby_q;

   // Decoded cycle
   logic selected;
   logic loadProc;
   logic loadCtrl;
   logic loadAny;
   logic startCycle;
   logic deselCycle;
   logic contCycle;
   logic advance;
   logic [SBSI_LANES-1:0] laneWr;
   logic writeReq;
   logic writeCycle;
   logic readCycle;
   logic [1:0] accessCount;
   logic [1:0] accessLow;
   logic [ADDR_W-1:0] accessAddr;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   // Select needs all three enables true
   assign selected = !enables.selectLowFirstN && enables.selectHigh
      && !enables.selectLowSecondN;

   // Processor strobe is ignored while the first enable is high,
   // so a shared processor bus cannot disturb an unselected part
   assign loadProc = !strobes.processorAddrStrobeN
      && !enables.selectLowFirstN;
   assign loadCtrl = !strobes.controllerAddrStrobeN && !loadProc;
   assign loadAny = (loadProc || loadCtrl) && !sleepRequest;

   // An accepted strobe with the part unselected is a deselect
   assign startCycle = loadAny && selected;
   assign deselCycle = loadAny && !selected;

   // Without a strobe an open burst continues on its internal address
   assign contCycle = !loadAny && !sleepRequest && (state_q == SBSI_BURST);
   assign advance = contCycle && !strobes.burstAdvanceN;

   // Byte lane decode: all-byte write overrides gate and selects
   always_comb begin
      if (!writeCtl.allByteWriteN) begin
         laneWr = SBSI_ALL_LANES;
      end else if (!writeCtl.byteWriteGateN) begin
         laneWr = ~writeCtl.laneWriteSelN;
      end else begin
         laneWr = SBSI_NO_LANES;
      end
   end
   assign writeReq = |laneWr;

   // A processor-strobe start is always a read
   assign writeCycle = writeReq && ((startCycle && loadCtrl) || contCycle);
   assign readCycle = (startCycle || contCycle) && !writeCycle;

   // ----------------------------------------------------------------
   // Burst address generation
   // ----------------------------------------------------------------
   // Counter value used by this access; a hold repeats the address
   always_comb begin
      if (startCycle) begin
         accessCount = SBSI_COUNT_RST;
      end else if (advance) begin
         accessCount = count_q + SBSI_COUNT_STEP;
      end else begin
         accessCount = count_q;
      end
   end

   // Order select: low counts linearly, high interleaves
   always_comb begin
      if (startCycle) begin
         accessLow = address[1:0];
      end else if (!burstOrderSelect) begin
         accessLow = base_q[1:0] + accessCount;
      end else begin
         accessLow = base_q[1:0] ^ accessCount;
      end
   end

   // Upper bits come straight from the pins on a load, every cycle if
   // wanted, so single accesses run at full rate
   assign accessAddr = startCycle ? address
      : {base_q[ADDR_W-1:2], accessLow};

   // Next burst state
   always_comb begin
      state_d = state_q;
      base_d = base_q;
      count_d = count_q;
      if (startCycle) begin
         state_d = SBSI_BURST;
         base_d = address;
         count_d = SBSI_COUNT_RST;
      end else if (deselCycle) begin
         state_d = SBSI_IDLE;
      end else if (contCycle) begin
         count_d = accessCount;
      end
   end

   // Burst state registers; sleep freezes them by blocking all cycles
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= SBSI_IDLE;
         base_q <= '0;
         count_q <= SBSI_COUNT_RST;
      end else begin
         state_q <= state_d;
         base_q <= base_d;
         count_q <= count_d;
      end
   end

   // ----------------------------------------------------------------
   // Array write
   // ----------------------------------------------------------------
   // The write finishes at the same edge that samples data, so the
   // controller holds nothing past it; the array is never reset
   always_ff @(posedge clock) begin
      if (writeCycle) begin
         for (int i = 0; i < SBSI_LANES; i++) begin
            if (laneWr[i]) begin
               mem[accessAddr][i*LANE_W +: LANE_W] <=
                  dataIn[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read pipeline and output drivers
   // ----------------------------------------------------------------
   // Stage one holds the array word, stage two the pin register;
   // a deselect or write clears the pending flag, which then passes stage two like a read
   always_comb begin
      readPend_d = readPend_q;
      readData_d = readData_q;
      if (!sleepRequest) begin
         readPend_d = readCycle;
         readData_d = readCycle ? mem[accessAddr] : readData_q;
      end
   end

   // Output stage; all four lanes carry read data
   always_comb begin
      driveEn_d = driveEn_q;
      dataOut_d = dataOut_q;
      if (!sleepRequest) begin
         driveEn_d = readPend_q;
         dataOut_d = readPend_q ? readData_q : dataOut_q;
      end
   end

   // Pipeline registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         readPend_q <= 1'b0;
         readData_q <= '0;
         driveEn_q <= 1'b0;
         dataOut_q <= '0;
      end else begin
         readPend_q <= readPend_d;
         readData_q <= readData_d;
         driveEn_q <= driveEn_d;
         dataOut_q <= dataOut_d;
      end
   end

   // Standby flag; sleep request is sampled here only for reporting
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         standby_q <= 1'b0;
      end else begin
         standby_q <= sleepRequest;
      end
   end

   assign dataOut = dataOut_q;
   assign standby = standby_q;

   // Enable is low while driving. Output enable and sleep gate the
   // registered enable without a clock, so they cannot come from a flop
   assign dataDriveN = {SBSI_LANES{!(driveEn_q && !outputEnableN
      && !sleepRequest)}};

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cbAssert @(posedge clock);
   endclocking
   default disable iff (reset);

   // Read captured now is on the pins two samples later
   property p_readLatency;
      readCycle ##1 !sleepRequest |-> ##1 driveEn_q
         && dataOut_q == $past(readData_q);
   endproperty
   a_readLatency: assert property (p_readLatency)
      else $error("read data not driven one edge after capture");

   // No drive follows a write
   property p_writeQuiet;
      writeCycle ##1 !sleepRequest |-> ##1 !driveEn_q;
   endproperty
   a_writeQuiet: assert property (p_writeQuiet)
      else $error("drivers on after a write cycle");

   // Deselect ends the drive one edge after capture
   property p_deselect;
      deselCycle ##1 !sleepRequest |-> ##1 !driveEn_q;
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("deselect did not turn drivers off");

   // Linear order steps the low address by one on each advance,
   // when the access before it was also in linear order
   property p_linear;
      advance && !burstOrderSelect && !$past(burstOrderSelect) |->
         accessLow == 2'($past(accessLow) + SBSI_COUNT_STEP);
   endproperty
   a_linear: assert property (p_linear)
      else $error("linear burst address wrong");

   // Interleaved order from base xor count
   property p_interleave;
      advance && burstOrderSelect |->
         accessLow == (base_q[1:0] ^ 2'(count_q + SBSI_COUNT_STEP));
   endproperty
   a_interleave: assert property (p_interleave)
      else $error("interleaved burst address wrong");

   // Hold when advance is high and no strobe
   property p_hold;
      contCycle && strobes.burstAdvanceN |=> $stable(count_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("counter moved without advance");

   // Dummy reads step the counter like normal reads
   property p_dummyAdvance;
      advance && readCycle && outputEnableN |=>
         count_q == 2'($past(count_q) + SBSI_COUNT_STEP);
   endproperty
   a_dummyAdvance: assert property (p_dummyAdvance)
      else $error("dummy read did not advance counter");

   // A start loads the pins into base and clears the count
   property p_preset;
      startCycle |=> base_q == $past(address) && count_q == SBSI_COUNT_RST;
   endproperty
   a_preset: assert property (p_preset)
      else $error("burst preset not loaded");

   // All-byte write enables every lane
   property p_allBytes;
      !writeCtl.allByteWriteN |-> laneWr == SBSI_ALL_LANES;
   endproperty
   a_allBytes: assert property (p_allBytes)
      else $error("all-byte write missed a lane");

   // Byte gate follows the lane selects
   property p_byteLanes;
      writeCtl.allByteWriteN && !writeCtl.byteWriteGateN |->
         laneWr == ~writeCtl.laneWriteSelN;
   endproperty
   a_byteLanes: assert property (p_byteLanes)
      else $error("byte lane decode wrong");

   // Unselected strobe never starts an access
   property p_select;
      loadAny && !selected |-> !startCycle && !writeCycle;
   endproperty
   a_select: assert property (p_select)
      else $error("access started while unselected");

   // Output enable high keeps every lane undriven
   property p_outEnable;
      outputEnableN || sleepRequest |-> &dataDriveN;
   endproperty
   a_outEnable: assert property (p_outEnable)
      else $error("drivers active with output enable high");

   // Sleep freezes burst state and the read pipeline
   property p_sleepFreeze;
      sleepRequest |=> $stable(state_q) && $stable(base_q) && $stable(count_q)
         && $stable(readPend_q);
   endproperty
   a_sleepFreeze: assert property (p_sleepFreeze)
      else $error("state moved during sleep");

   // Main scenarios
   c_fullBurst: cover property (startCycle ##1 advance [*3]);
   c_writeStart: cover property (startCycle && writeCycle);
   c_readThenDesel: cover property (readCycle ##1 deselCycle);
   c_backToBack: cover property (startCycle ##1 startCycle ##1 startCycle);
   c_dummyRead: cover property (advance && readCycle && outputEnableN);

endmodule

// ### pkg/sbsi_pkg.sv
// ----------------------------------------------------------------------
// Shared constants and carriers of the burst memory interface
// ----------------------------------------------------------------------
package sbsi_pkg;

   // Geometry: four byte lanes of nine bits each
   localparam int SBSI_ADDR_W = 18;
   localparam int SBSI_LANES = 4;
   localparam int SBSI_LANE_W = 9;
   localparam int SBSI_BURST_W = 2;

   // Reset and step values of the burst counter, and the all-lane and no-lane masks
   localparam logic [1:0] SBSI_COUNT_RST = 2'h0;
   localparam logic [1:0] SBSI_COUNT_STEP = 2'h1;
   localparam logic [3:0] SBSI_ALL_LANES = 4'hF;
   localparam logic [3:0] SBSI_NO_LANES = 4'h0;

   // Burst tracking state
   typedef enum logic [1:0] {
      SBSI_IDLE  = 2'b01,
      SBSI_BURST = 2'b10
   } sbsi_state_t;

   // Chip enable pins, sampled on the rising edge
   typedef struct packed {
      logic selectLowFirstN;
      logic selectHigh;
      logic selectLowSecondN;
   } sbsi_enable_t;

   // Address strobes and burst advance, all active low
   typedef struct packed {
      logic processorAddrStrobeN;
      logic controllerAddrStrobeN;
      logic burstAdvanceN;
   } sbsi_strobe_t;

   // Write controls, all active low; bit n of the selects is lane n
   typedef struct packed {
      logic allByteWriteN;
      logic byteWriteGateN;
      logic [SBSI_LANES-1:0] laneWriteSelN;
   } sbsi_write_t;

endpackage

// ### verification/sbsi_ctrl_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Controller side of the synchronous bus
// ----------------------------------------------------------------------
module sbsi_ctrl_model #(
   parameter int AW = 4
) (
   input wire logic clock,
   output logic [AW-1:0] address,
   output sbsi_pkg::sbsi_enable_t enables,
   output sbsi_pkg::sbsi_strobe_t strobes,
   output sbsi_pkg::sbsi_write_t writeCtl,
   output logic [35:0] dataIn
);
   import sbsi_pkg::*;

   // Quiet bus until the first command: deselected, strobes off, no write
   initial begin
      address = '0;
      enables = 3'h5;
      strobes = 3'h7;
      writeCtl = 6'h3F;
      dataIn = 36'h0_0000_0000;
   end

   // One command per cycle, launched by non-blocking assignment after the edge
   task automatic issue(input sbsi_enable_t e, input sbsi_strobe_t s, input sbsi_write_t w,
      input logic [AW-1:0] a, input logic [35:0] d);
      @(posedge clock);
      enables <= e;
      strobes <= s;
      writeCtl <= w;
      address <= a;
      // Released data shows the inverse of its last value, so stale data never matches
      if (w.allByteWriteN && (w.byteWriteGateN || (&w.laneWriteSelN))) begin
         dataIn <= ~dataIn;
      end else begin
         dataIn <= d;
      end
   endtask
endmodule

// ### verification/test_sync_burst_sram_interface.sv
`timescale 1ns/10ps
module test_sync_burst_sram_interface;
   import sbsi_pkg::*;
   localparam int AW = 4;
   localparam sbsi_enable_t ON = 3'h2;
   localparam sbsi_enable_t OFF = 3'h3;
   localparam sbsi_write_t RD = 6'h3F;
   localparam sbsi_write_t WR_ALL = 6'h1F;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic outputEnableN = 1'b0;
   logic sleepRequest = 1'b0;
   logic burstOrderSelect = 1'b0;
   logic [AW-1:0] address;
   sbsi_enable_t enables;
   sbsi_strobe_t strobes;
   sbsi_write_t writeCtl;
   logic [35:0] dataIn;
   logic [35:0] dataOut;
   logic [3:0] dataDriveN;
   logic standby;
   int n_errors = 0;
   int comparisons = 0;
   int seed;
   // Reference state
   logic [35:0] mem [16];
   logic [AW-1:0] baseAddr = '0;
   logic [1:0] cnt = 2'h0;
   logic open = 1'b0;
   logic expRd = 1'b0;
   logic expDrv = 1'b0;
   logic expSleep = 1'b0;
   logic [35:0] expRdData;
   logic [35:0] expData;

   always #25 clock = ~clock;

   sbsi_core #(.ADDR_W(AW)) u_dut (.clock(clock), .reset(reset), .address(address),
      .enables(enables), .strobes(strobes), .writeCtl(writeCtl), .dataIn(dataIn),
      .outputEnableN(outputEnableN), .sleepRequest(sleepRequest),
      .burstOrderSelect(burstOrderSelect), .dataOut(dataOut), .dataDriveN(dataDriveN),
      .standby(standby));

   sbsi_ctrl_model #(.AW(AW)) u_ctrl (.clock(clock), .address(address), .enables(enables),
      .strobes(strobes), .writeCtl(writeCtl), .dataIn(dataIn));

   // ----------------------------------------------------------------------
   // Reference model, stepped on the same edges as the device
   // ----------------------------------------------------------------------
   always @(posedge clock or posedge reset) begin : model_step
      logic loadP, loadC, sel, start, cont, wr;
      logic [3:0] lanes;
      logic [AW-1:0] a;
      if (reset) begin
         open = 1'b0;
         cnt = 2'h0;
         expRd = 1'b0;
         expDrv = 1'b0;
         expSleep = 1'b0;
      end else begin
         expSleep = sleepRequest;
         // Sleep freezes every piece of state, the read pipeline included
         if (!sleepRequest) begin
            expDrv = expRd;
            expData = expRdData;
            loadP = !strobes.processorAddrStrobeN && !enables.selectLowFirstN;
            loadC = !strobes.controllerAddrStrobeN && !loadP;
            sel = !enables.selectLowFirstN && enables.selectHigh && !enables.selectLowSecondN;
            start = (loadP || loadC) && sel;
            cont = !(loadP || loadC) && open;
            lanes = !writeCtl.allByteWriteN ? 4'hF :
               (!writeCtl.byteWriteGateN ? ~writeCtl.laneWriteSelN : 4'h0);
            wr = (lanes != 4'h0) && ((start && loadC) || cont);
            if (loadP || loadC) open = sel;
            if (start) begin
               baseAddr = address;
               cnt = 2'h0;
            end else if (cont && !strobes.burstAdvanceN) begin
               cnt = cnt + 2'h1;
            end
            a = {baseAddr[AW-1:2], burstOrderSelect ? baseAddr[1:0] ^ cnt : baseAddr[1:0] + cnt};
            for (int i = 0; i < 4; i++) begin
               if (wr && lanes[i]) mem[a][9*i +: 9] = dataIn[9*i +: 9];
            end
            expRd = (start || cont) && !wr;
            expRdData = mem[a];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Comparisons and closing
   // ----------------------------------------------------------------------
   task automatic cmp_drive(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH drive t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_data(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH data t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH standby t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Settled outputs are looked at mid-cycle, away from the launching edge
   always @(negedge clock) begin
      if (!reset) begin
         cmp_drive(dataDriveN, (expDrv && !outputEnableN && !sleepRequest) ? 4'h0 : 4'hF);
         cmp_flag(standby, expSleep);
         if (expDrv && !outputEnableN && !sleepRequest) cmp_data(dataOut, expData);
      end
   end

   // ----------------------------------------------------------------------
   // Stimulus helpers
   // ----------------------------------------------------------------------
   function automatic logic [35:0] rnd36();
      return 36'({$urandom, $urandom});
   endfunction

   task automatic op(input sbsi_enable_t e, input logic p, input logic c, input logic step,
      input sbsi_write_t w, input int a);
      u_ctrl.issue(e, {p, c, step}, w, AW'(a), rnd36());
   endtask

   // Start on either strobe, then n continues with fixed or random advance
   task automatic burst(input logic useProc, input sbsi_write_t w, input int a, input int n,
      input logic rndStep);
      op(ON, !useProc, useProc, 1'b1, w, a);
      repeat (n) op(ON, 1'b1, 1'b1, rndStep ? 1'($urandom) : 1'b0, w, a);
   endtask

   initial begin
      #(50 * 3000);
      n_errors++;
      report_and_stop;
   end

   initial begin
      seed = $urandom(73);
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      for (int b = 0; b < 16; b += 4) burst(1'b0, WR_ALL, b, 3, 1'b0);
      // Every start offset in both orders, wrapping on the fifth clock
      for (int m = 0; m < 16; m++) begin
         burstOrderSelect <= m[0];
         burst(m[1], RD, {m[1:0], m[3:2]}, 4, 1'b0);
      end
      for (int m = 0; m < 8; m++) burst(m[0], RD, m * 2, 5, 1'b1);
      // Each lane combination, read straight back without a burst
      for (int i = 0; i < 16; i++) begin
         op(ON, 1'b1, 1'b0, 1'b1, {2'h2, 4'(~i)}, i);
         op(ON, 1'b1, 1'b0, 1'b1, 6'h30, i);
      end
      burst(1'b0, {2'h2, 4'h5}, 8, 3, 1'b1);
      // Full-rate random commands: reads low half, random write controls (some of them reads) high half
      repeat (60) begin
         if ($urandom % 2) op(ON, 1'($urandom), 1'b0, 1'b1, RD, $urandom % 8);
         else op(ON, 1'b1, 1'b0, 1'b1, {1'($urandom), 5'($urandom)}, 8 + $urandom % 8);
      end
      for (int i = 0; i < 16; i++) op(ON, 1'b1, 1'b0, 1'b1, RD, i);
      // Chip enable combinations on both strobes, each read cut by a deselect
      for (int i = 0; i < 16; i++) begin
         op(3'(i), i[3], !i[3], 1'b0, RD, i);
         op(OFF, 1'b1, 1'b0, 1'b1, RD, 0);
      end
      // Output enable dropped mid-read, then dummy reads keep counting
      op(ON, 1'b1, 1'b0, 1'b1, RD, 5);
      op(ON, 1'b1, 1'b1, 1'b0, RD, 0);
      #20 outputEnableN = 1'b1;
      #1 cmp_drive(dataDriveN, 4'hF);
      repeat (2) op(ON, 1'b1, 1'b1, 1'b0, RD, 0);
      outputEnableN <= 1'b0;
      repeat (3) op(ON, 1'b1, 1'b1, 1'b0, RD, 0);
      // Sleep taken mid-read refuses a write and keeps the stored word
      op(ON, 1'b1, 1'b0, 1'b1, RD, 5);
      op(ON, 1'b1, 1'b1, 1'b1, RD, 0);
      #20 sleepRequest = 1'b1;
      #1 cmp_drive(dataDriveN, 4'hF);
      repeat (4) op(ON, 1'b1, 1'b0, 1'b1, WR_ALL, 5);
      // Sleep is let go only with a deselect on the bus, so no write slips in
      op(OFF, 1'b1, 1'b0, 1'b1, RD, 0);
      sleepRequest <= 1'b0;
      burst(1'b1, RD, 5, 1, 1'b0);
      repeat (3) op(OFF, 1'b1, 1'b0, 1'b1, RD, 0);
      report_and_stop;
   end
endmodule
